// ==== hdl/sgl_pkg.sv ====
// Constants and types for the serial enclosure LED transmitter.
// Assumes a 200 MHz pclk and an APB register bus with 32-bit data.
package sgl_pkg;

    // ********************************
    // Bus and register map
    // ********************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CTL = 12'h000; // Transmit and reset control
    localparam logic [11:0] OFS_CFG = 12'h004; // Port config, vendor pattern
    localparam logic [11:0] OFS_PI = 12'h008; // Ports implemented
    localparam logic [11:0] OFS_LOC = 12'h00c; // Message location, read only
    localparam logic [11:0] OFS_STS = 12'h010; // Link status, read only
    localparam logic [11:0] OFS_MSG_HDR = 12'h580; // Message header word
    localparam logic [11:0] OFS_MSG_BODY = 12'h584; // LED message body
    // Location: dword offset in upper half, buffer size in dwords in lower
    localparam logic [31:0] LOC_VALUE = 32'h0160_0002;

    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int TRANSMIT_MESSAGE_BIT_BIT = 0;
    localparam int CTL_RST_BIT = 1;
    localparam int CFG_PCFG_LSB = 0;
    localparam int CFG_VEND_LSB = 4;
    localparam int CFG_HWACT_LSB = 8;
    localparam logic [1:0] PCFG_4 = 2'h0;
    localparam logic [1:0] PCFG_6 = 2'h1;
    localparam logic [1:0] PCFG_8 = 2'h2;
    localparam logic [1:0] PCFG_RST = 2'h2;
    localparam logic [3:0] VEND_RST = 4'h0;
    localparam logic [7:0] PI_RST = 8'hff;
    localparam logic [2:0] LED_RST = 3'h7;
    localparam int HDR_TYPE_LSB = 8;
    localparam logic [3:0] MSG_TYPE_LED = 4'h0;
    localparam int BODY_PORT_LSB = 0;
    localparam int BODY_LED_LSB = 16;

    // ********************************
    // Frame shape and timing
    // ********************************
    localparam int NUM_PORTS = 8;
    localparam int LED_BITS = 3;
    localparam logic [4:0] LEAD_BITS = 5'h05;
    localparam logic [4:0] VEND_BITS = 5'h04;
    localparam logic [4:0] DATA_BITS = 5'h18;
    localparam logic [4:0] OUT1_HALF = 5'h0c;
    localparam logic [4:0] OUT1_LEN8 = 5'h0c;
    localparam logic [4:0] OUT1_LEN6 = 5'h06;
    localparam int PCLK_PERIOD_NS = 5;
    localparam int SCLK_PERIOD_NS = 80;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

    typedef enum logic [3:0] {
        SGL_IDLE = 4'h1,
        SGL_LEAD = 4'h2,
        SGL_LOAD = 4'h4,
        SGL_DATA = 4'h8
    } sgl_state_t;

endpackage

// ==== hdl/sgl_clkdiv.sv ====
// Shift clock divider for the serial LED link.
// Assumes run is a registered level in the pclk domain.
`timescale 1ns/1ps
module sgl_clkdiv
    import sgl_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic sclk,
    output logic fall_tick
);

    // Half period counter
    logic [7:0] cnt;
    logic wrap;

    assign wrap = run && (cnt == 8'(HALF - 1));
    // Pulse in the cycle whose closing edge drops the clock
    assign fall_tick = wrap && sclk;

    // ********************************
    // Counter and clock level
    // ********************************
    // Clock rests low while stopped, starts low on run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            sclk <= 1'b0;
        end else if (!run) begin
            cnt <= 8'h00;
            sclk <= 1'b0;
        end else if (wrap) begin
            cnt <= 8'h00;
            sclk <= ~sclk;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

endmodule

// ==== hdl/sgl_led_image.sv ====
// Builds the 24-bit LED image sent on the serial link.
// Assumes all inputs are in the pclk domain.
`timescale 1ns/1ps
module sgl_led_image
    import sgl_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic [PORTS*LED_BITS-1:0] led_flat,
    input wire logic [PORTS-1:0] port_impl,
    input wire logic [PORTS-1:0] hw_act_en,
    input wire logic [PORTS-1:0] port_activity,
    output logic [PORTS*LED_BITS-1:0] image
);

    // ********************************
    // Per port field: activity, locate, fault
    // ********************************
    always_comb begin
        image = led_flat;
        for (int p = 0; p < PORTS; p++) begin
            // Activity from the port itself when hardware driven
            if (hw_act_en[p]) begin
                image[p*LED_BITS] = port_activity[p];
            end
            // Unimplemented port sends all ones
            if (!port_impl[p]) begin
                image[p*LED_BITS +: LED_BITS] = LED_RST;
            end
        end
    end

endmodule

// ==== hdl/sgl_tx.sv ====
// Serial enclosure LED transmitter with APB registers.
// Assumes mode and activity inputs come from pclk-domain logic.
`timescale 1ns/1ps
// Summary of operation
// - Message buffer sits at byte 580h
// - Only LED messages update the LEDs
// - Pins float until first transmit request
// - Frame opens with strobe low, five clocks
// - Strobe high one clock, then vendor pattern
// - Out0 sends 24 bits, ports ascending
// - Eight ports: out1 12 bits, then float
// - Six ports: out1 6 bits, then float
// - Four ports: out1 always floats
// - LED bits default high; activity may follow port
// - Unimplemented ports send all ones
// - Platform reset floats pins at once
// - Sync reset ends frame, then floats
// - Slot LEDs hold until next update
// - Operates only in advanced or RAID mode
// - Transmit only: clock, strobe, data outputs
module sgl_tx
    import sgl_pkg::*;
#(
    parameter int HALF = SCLK_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ahci_mode_ok,
    input wire logic host_ctrl_reset,
    input wire logic [NUM_PORTS-1:0] port_activity,
    output logic serial_shift_clock,
    output logic serial_shift_clock_oe,
    output logic frame_load_strobe,
    output logic frame_load_strobe_oe,
    output logic serial_led_out0,
    output logic serial_led_out0_oe,
    output logic serial_led_out1,
    output logic serial_led_out1_oe
);

    // ********************************
    // Declarations
    // ********************************
    logic acc_ack; // Access phase answered this cycle
    logic wr_en; // Write takes effect
    logic transmit_message_bit; // Transmit request
    logic serial_sync_reset_bit; // Pending synchronous reset
    logic tm_taken; // Request latched into current frame
    logic [1:0] port_cfg; // Port count select
    logic [3:0] vend_pat; // Vendor pattern on strobe
    logic [NUM_PORTS-1:0] hw_act_en; // Hardware activity per port
    logic [NUM_PORTS-1:0] port_impl; // Ports implemented
    logic [31:0] msg_hdr; // Buffer header word
    logic [31:0] msg_body; // Buffer LED body word
    logic [LED_BITS-1:0] led_state [NUM_PORTS]; // Held slot LEDs
    logic [NUM_PORTS*LED_BITS-1:0] led_flat; // Flattened slot LEDs
    logic [NUM_PORTS*LED_BITS-1:0] img_now; // Composed image
    logic [NUM_PORTS*LED_BITS-1:0] img_snap; // Image for this frame
    logic [3:0] vend_snap; // Pattern for this frame
    sgl_state_t st, next_st; // Frame state
    logic [4:0] bit_cnt, next_cnt; // Bit period counter
    logic fall_tick; // Shift clock about to fall
    logic frame_end; // Last data bit done
    logic frame_start; // New frame begins
    logic msg_ok; // Buffer holds a usable LED message
    logic [2:0] msg_port; // Target slot of message
    logic [4:0] out1_len; // Driven bits on out1
    logic sclk; // Divider clock level

    // Register hit for unmapped detection
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return a == OFS_CTL || a == OFS_CFG || a == OFS_PI || a == OFS_LOC ||
            a == OFS_STS || a == OFS_MSG_HDR || a == OFS_MSG_BODY;
    endfunction

    // ********************************
    // APB slave, one wait state
    // ********************************
    assign pready = acc_ack;
    assign wr_en = acc_ack && pwrite;

    // Answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ack <= 1'b0;
        end else begin
            acc_ack <= psel && penable && !acc_ack;
        end
    end

    // Read data and error captured on the edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !acc_ack) begin
            pslverr <= !reg_hit(paddr);
            unique case (paddr)
                OFS_CTL: prdata <= {30'h0, serial_sync_reset_bit, transmit_message_bit};
                OFS_CFG: prdata <= {16'h0, hw_act_en, vend_pat, 2'h0, port_cfg};
                OFS_PI: prdata <= {24'h0, port_impl};
                OFS_LOC: prdata <= LOC_VALUE;
                OFS_STS: prdata <= {29'h0, ahci_mode_ok, st != SGL_IDLE,
                    serial_shift_clock_oe};
                OFS_MSG_HDR: prdata <= msg_hdr;
                OFS_MSG_BODY: prdata <= msg_body;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_cfg <= PCFG_RST;
            vend_pat <= VEND_RST;
            hw_act_en <= '0;
            port_impl <= PI_RST;
        end else if (wr_en && paddr == OFS_CFG) begin
            port_cfg <= pwdata[CFG_PCFG_LSB +: 2];
            vend_pat <= pwdata[CFG_VEND_LSB +: 4];
            hw_act_en <= pwdata[CFG_HWACT_LSB +: NUM_PORTS];
        end else if (wr_en && paddr == OFS_PI) begin
            port_impl <= pwdata[NUM_PORTS-1:0];
        end
    end

    // Message buffer words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_hdr <= 32'h0000_0000;
            msg_body <= 32'h0000_0000;
        end else if (wr_en && paddr == OFS_MSG_HDR) begin
            msg_hdr <= pwdata;
        end else if (wr_en && paddr == OFS_MSG_BODY) begin
            msg_body <= pwdata;
        end
    end

    // ********************************
    // Transmit and reset control bits
    // ********************************
    // Hardware clears at frame end; a software set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_message_bit <= 1'b0;
            tm_taken <= 1'b0;
        end else begin
            if (wr_en && paddr == OFS_CTL && pwdata[TRANSMIT_MESSAGE_BIT_BIT] && ahci_mode_ok) begin
                transmit_message_bit <= 1'b1;
                tm_taken <= 1'b0;
            end else if ((frame_end && tm_taken) ||
                (st == SGL_IDLE && serial_sync_reset_bit)) begin
                // Clear first, or the repeat frame would re-take it
                transmit_message_bit <= 1'b0;
                tm_taken <= 1'b0;
            end else if (frame_start && transmit_message_bit) begin
                tm_taken <= 1'b1;
            end
        end
    end

    // Sync reset pends until the frame completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_sync_reset_bit <= 1'b0;
        end else if (host_ctrl_reset ||
            (wr_en && paddr == OFS_CTL && pwdata[CTL_RST_BIT])) begin
            serial_sync_reset_bit <= 1'b1;
        end else if (st == SGL_IDLE) begin
            serial_sync_reset_bit <= 1'b0;
        end
    end

    // ********************************
    // Slot LED store
    // ********************************
    assign msg_port = msg_body[BODY_PORT_LSB +: 3];
    // Only LED type with an in-range host port is applied
    assign msg_ok = msg_hdr[HDR_TYPE_LSB +: 4] == MSG_TYPE_LED &&
        msg_body[BODY_PORT_LSB+3 +: 5] == 5'h00;

    // Update one slot per request, others hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                led_state[p] <= LED_RST;
            end
        end else if (frame_start && transmit_message_bit && !tm_taken && msg_ok) begin
            led_state[msg_port] <= msg_body[BODY_LED_LSB +: LED_BITS];
        end
    end

    // Flatten slots, port 0 first
    always_comb begin
        led_flat = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            led_flat[p*LED_BITS +: LED_BITS] = led_state[p];
        end
    end

    sgl_led_image #(
        .PORTS(NUM_PORTS)
    ) u_image (
        .led_flat(led_flat),
        .port_impl(port_impl),
        .hw_act_en(hw_act_en),
        .port_activity(port_activity),
        .image(img_now)
    );

    // ********************************
    // Shift clock and frame sequencer
    // ********************************
    sgl_clkdiv #(
        .HALF(HALF)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(st != SGL_IDLE),
        .sclk(sclk),
        .fall_tick(fall_tick)
    );

    assign frame_start = next_st == SGL_LEAD && st != SGL_LEAD;

    // Next state, stepping on falling shift clock
    always_comb begin
        next_st = st;
        next_cnt = bit_cnt;
        frame_end = 1'b0;
        unique case (st)
            SGL_IDLE: begin
                // Start with strobe low at once
                if (transmit_message_bit && ahci_mode_ok && !serial_sync_reset_bit) begin
                    next_st = SGL_LEAD;
                    next_cnt = 5'h00;
                end
            end
            SGL_LEAD: begin
                if (fall_tick && bit_cnt == LEAD_BITS - 5'h01) begin
                    next_st = SGL_LOAD;
                    next_cnt = 5'h00;
                end else if (fall_tick) begin
                    next_cnt = bit_cnt + 5'h01;
                end
            end
            SGL_LOAD: begin
                if (fall_tick) begin
                    next_st = SGL_DATA;
                    next_cnt = 5'h00;
                end
            end
            SGL_DATA: begin
                if (fall_tick && bit_cnt == DATA_BITS - 5'h01) begin
                    frame_end = 1'b1;
                    // Stop only on a frame boundary
                    next_st = (serial_sync_reset_bit || !ahci_mode_ok) ?
                        SGL_IDLE : SGL_LEAD;
                    next_cnt = 5'h00;
                end else if (fall_tick) begin
                    next_cnt = bit_cnt + 5'h01;
                end
            end
        endcase
    end

    // State registers; platform reset floats immediately
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= SGL_IDLE;
            bit_cnt <= 5'h00;
        end else begin
            st <= next_st;
            bit_cnt <= next_cnt;
        end
    end

    // Snapshot image and pattern as the load bit starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img_snap <= '1;
            vend_snap <= VEND_RST;
        end else if (next_st == SGL_LOAD && st == SGL_LEAD) begin
            img_snap <= img_now;
            vend_snap <= vend_pat;
        end
    end

    // ********************************
    // Pin drivers
    // ********************************
    // Out1 length from port configuration
    always_comb begin
        unique case (port_cfg)
            PCFG_8: out1_len = OUT1_LEN8;
            PCFG_6: out1_len = OUT1_LEN6;
            default: out1_len = 5'h00;
        endcase
    end

    assign serial_shift_clock = sclk;

    // Outputs register alongside state, so they move with the fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_shift_clock_oe <= 1'b0;
            frame_load_strobe <= 1'b0;
            frame_load_strobe_oe <= 1'b0;
            serial_led_out0 <= 1'b0;
            serial_led_out0_oe <= 1'b0;
            serial_led_out1 <= 1'b0;
            serial_led_out1_oe <= 1'b0;
        end else begin
            serial_shift_clock_oe <= next_st != SGL_IDLE;
            frame_load_strobe_oe <= next_st != SGL_IDLE;
            serial_led_out0_oe <= next_st != SGL_IDLE;
            serial_led_out1_oe <= next_st == SGL_DATA && next_cnt < out1_len;
            frame_load_strobe <= next_st == SGL_LOAD ||
                (next_st == SGL_DATA && next_cnt < VEND_BITS &&
                vend_snap[2'(VEND_BITS - 5'h01 - next_cnt)]);
            serial_led_out0 <= next_st == SGL_DATA && img_snap[next_cnt];
            serial_led_out1 <= next_st == SGL_DATA &&
                img_snap[5'(OUT1_HALF + next_cnt)];
        end
    end

    // ********************************
    // Assertions
    // ********************************
    // Cycles spent in the load bit
    logic [7:0] load_cyc;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cyc <= 8'h00;
        end else begin
            load_cyc <= (st == SGL_LOAD) ? load_cyc + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lead_done;
        st == SGL_LEAD && fall_tick && bit_cnt == LEAD_BITS - 5'h01;
    endsequence
    sequence s_load_bit;
        st == SGL_LOAD && frame_load_strobe && frame_load_strobe_oe;
    endsequence

    a_idle_floats: assert property (st == SGL_IDLE |->
        !serial_shift_clock_oe && !frame_load_strobe_oe && !serial_led_out0_oe)
        else $error("pins driven while idle");
    a_lead_low: assert property (st == SGL_LEAD |->
        frame_load_strobe_oe && !frame_load_strobe)
        else $error("strobe not low in lead");
    a_lead_five: assert property ($rose(st == SGL_LOAD) |->
        $past(bit_cnt) == 5'h04)
        else $error("lead not five clocks");
    a_load_one: assert property (s_lead_done |=> s_load_bit)
        else $error("load bit not driven high");
    a_load_length: assert property ($rose(st == SGL_DATA) |->
        load_cyc == 8'(2 * HALF))
        else $error("load bit length wrong");
    a_vendor_bits: assert property (st == SGL_DATA && bit_cnt < 5'h04 |->
        frame_load_strobe == vend_snap[2'(5'h03 - bit_cnt)])
        else $error("vendor pattern wrong");
    a_data_bits: assert property (st == SGL_DATA |->
        serial_led_out0 == img_snap[bit_cnt])
        else $error("out0 bit mismatch");
    a_out1_tail: assert property (next_st == SGL_DATA && next_cnt >= out1_len |=>
        !serial_led_out1_oe)
        else $error("out1 driven in tail");
    a_out1_four: assert property (port_cfg == PCFG_4 |=> !serial_led_out1_oe)
        else $error("out1 driven, four ports");
    a_unimpl_ones: assert property (st == SGL_LOAD |->
        (img_now[2:0] == 3'h7 || port_impl[0]) && (img_now[23:21] == 3'h7 || port_impl[7]))
        else $error("unimplemented port not ones");
    a_sync_waits: assert property (serial_sync_reset_bit && st == SGL_DATA &&
        !frame_end |=> st == SGL_DATA)
        else $error("frame cut by sync reset");
    a_sync_stop: assert property (frame_end && serial_sync_reset_bit |=>
        st == SGL_IDLE ##1 !serial_led_out0_oe)
        else $error("sync reset did not float");
    a_mode_gate: assert property (st == SGL_IDLE && !ahci_mode_ok |=> st == SGL_IDLE)
        else $error("start outside mode");
    a_edge_align: assert property ($changed(serial_led_out0) &&
        $past(serial_led_out0_oe) && serial_led_out0_oe |-> $past(fall_tick))
        else $error("data moved off falling edge");

endmodule

// ==== verif/sgl_encl_rx.sv ====
// Enclosure controller model that deserializes each LED frame.
// Assumes link outputs change on falling shift clock edges.
`timescale 1ns/1ps
module sgl_encl_rx (
    input wire logic sclk,
    input wire logic load,
    input wire logic d0,
    input wire logic d1,
    input wire logic d1_oe,
    output logic [23:0] img,
    output logic [11:0] img1,
    output logic [3:0] vend,
    output logic [31:0] lead,
    output logic [31:0] n1,
    output logic [31:0] frames
);
    int pos = 24; // Bit slot, 24 between frames
    int run = 0; // Strobe-low clocks seen
    initial begin
        frames = 0;
        n1 = 0;
        lead = 0;
    end
    // Sample mid-bit on rising shift clock
    always @(posedge sclk) begin
        if (pos < 24) begin
            img[pos] = d0;
            if (pos < 12) img1[pos] = d1;
            if (pos < 4) vend[3 - pos] = load;
            if (d1_oe) n1++;
            if (pos == 23) frames++;
            pos++;
        end else if (load) begin
            lead = run;
            run = 0;
            pos = 0;
            n1 = 0;
        end else begin
            run++;
        end
    end
endmodule

// ==== verif/sgl_tx_tb.sv ====
// Self-checking bench for the serial enclosure LED transmitter.
// Assumes the enclosure model captures each frame on the link.
`timescale 1ns/1ps
module sgl_tx_tb;
    import sgl_pkg::*;
    typedef struct {
        logic [31:0] cfg;
        logic [7:0] pi;
        logic [31:0] hdr;
        logic [31:0] body;
        logic [31:0] n1;
    } sgl_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ahci_mode_ok = 1, host_ctrl_reset = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, rx_lead, rx_n1, rx_frames, f;
    logic [7:0] port_activity = 0;
    logic pready, pslverr, err, sck, sck_oe, ld, ld_oe, d0, d0_oe, d1, d1_oe;
    logic [23:0] rx_img, e;
    logic [11:0] rx_img1, m;
    logic [3:0] rx_vend, oes;
    logic [2:0] led [8] = '{default: 3'h7}; // Expected slot states
    int miscompares = 0, tests_run = 0, cycles = 0;
    // Config, ports implemented, header, body, out1 bits driven
    sgl_row_t rows [5] = '{
        '{32'h02, 8'hff, 32'h100, 32'h0, 12}, // Non-LED type
        '{32'h02, 8'hff, 32'h0, 32'h2_0000, 12}, // Port 0 locate
        '{32'h51, 8'hff, 32'h0, 32'h0_0007, 6}, // Port 7 off, six ports
        '{32'ha0, 8'h7f, 32'h0, 32'h5_0003, 0}, // Port 7 unimplemented
        '{32'h0802, 8'hff, 32'h0, 32'h0_0009, 12} // Host port out of range, port 3 hw activity
    };
    assign oes = {sck_oe, ld_oe, d0_oe, d1_oe};
    always #2.5 pclk = ~pclk;
    sgl_tx uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ahci_mode_ok(ahci_mode_ok), .host_ctrl_reset(host_ctrl_reset),
        .port_activity(port_activity), .serial_shift_clock(sck), .serial_shift_clock_oe(sck_oe),
        .frame_load_strobe(ld), .frame_load_strobe_oe(ld_oe), .serial_led_out0(d0),
        .serial_led_out0_oe(d0_oe), .serial_led_out1(d1), .serial_led_out1_oe(d1_oe));
    sgl_encl_rx far_end (.sclk(sck), .load(ld), .d0(d0), .d1(d1), .d1_oe(d1_oe), .img(rx_img),
        .img1(rx_img1), .vend(rx_vend), .lead(rx_lead), .n1(rx_n1), .frames(rx_frames));
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Platform reset; pins must float before any edge
    task automatic do_reset();
        presetn <= 1'b0;
        #1;
        check("pins in reset", oes, 0);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic wait_tm();
        int n = 0;
        do begin
            apb(0, OFS_CTL, 0);
            n++;
        end while (rd[0] !== 1'b0 && n < 400);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        do_reset();
        repeat (50) @(posedge pclk);
        check("pins before first frame", oes, 0);
        apb(0, OFS_LOC, 0);
        check("location", rd, LOC_VALUE);
        apb(0, OFS_CFG, 0);
        check("config reset", rd, 32'h2);
        apb(0, OFS_PI, 0);
        check("ports reset", rd, 32'hff);
        apb(0, 12'h100, 0);
        check("unmapped", {rd[30:0], err}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            apb(1, OFS_CFG, rows[i].cfg);
            apb(1, OFS_PI, {24'h0, rows[i].pi});
            apb(1, OFS_MSG_HDR, rows[i].hdr);
            apb(1, OFS_MSG_BODY, rows[i].body);
            if (rows[i].hdr[11:8] === MSG_TYPE_LED && rows[i].body[7:0] < 8)
                led[rows[i].body[2:0]] = rows[i].body[18:16];
            for (int p = 0; p < 8; p++) e[3*p +: 3] = !rows[i].pi[p] ? 3'h7 :
                {led[p][2:1], rows[i].cfg[8+p] ? port_activity[p] : led[p][0]};
            apb(1, OFS_CTL, 32'h1);
            wait_tm();
            m = 12'hfff >> (12 - rows[i].n1);
            check("image", rx_img, e);
            check("out1", rx_img1 & m, e[23:12] & m);
            check("out1 count", rx_n1, rows[i].n1);
            check("vendor", rx_vend, rows[i].cfg[7:4]);
            check("lead", rx_lead >= 5, 1);
        end
        f = rx_frames;
        apb(1, OFS_CTL, 32'h2);
        for (int n = 0; n < 2000 && oes !== 4'h0; n++) @(posedge pclk);
        check("frames at sync reset", rx_frames, f + 1);
        repeat (600) @(posedge pclk);
        check("pins after sync reset", oes, 0);
        do_reset();
        ahci_mode_ok <= 1'b0;
        apb(1, OFS_CTL, 32'h1);
        apb(0, OFS_CTL, 0);
        check("start with mode off", {rd[0], oes}, 0);
        ahci_mode_ok <= 1'b1;
        apb(1, OFS_CTL, 32'h1);
        repeat (20) @(posedge pclk);
        check("pins on start", oes, 4'he);
        f = rx_frames;
        host_ctrl_reset <= 1'b1;
        @(posedge pclk);
        host_ctrl_reset <= 1'b0;
        for (int n = 0; n < 2000 && oes !== 4'h0; n++) @(posedge pclk);
        check("frames at host reset", rx_frames, f + 1);
        apb(1, OFS_CTL, 32'h1);
        repeat (20) @(posedge pclk);
        do_reset();
        end_of_test();
    end
endmodule
